// file: hdl/twm_timer_ctrl.sv
// timer wave mode, output forcing, commands, update lock and buffer valid control
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "twm_defs.svh"

// Summary of operation
// - mode 0 normal, 1 frequency, channel zero top
// - mode 3 single slope, events at bottom
// - modes 5-7 dual slope, wrap varies
// - normal mode drives no waveform
// - waveform reaches pin only when enabled
// - force bits set levels while stopped
// - split bit makes two 8-bit counters
// - clear alias clears only one bits
// - set alias sets only one bits
// - command none, update, restart; reads zero
// - hard reset command ignored while enabled
// - unlocked update copies buffers at once
// - locked update copies no buffers
// - direction bit, software may change it
// - compare buffer write sets its flag
// - period buffer write sets its flag
// - update clears all buffer valid flags
// - auto lock holds lock until buffers valid
// - wrap flag sticky, cleared by one write
module twm_timer_ctrl (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// waveform pins
	output twm_pkg::twm_pins_s wave_pins
);
	import twm_pkg::*;

	twm_state_s s; // registered state
	twm_state_s next_s; // next state
	logic wr_fire; // write data phase completes now
	logic [7:0] wr_idx; // register index being written
	logic [1:0] cmd; // command issued this cycle
	logic hard_rst; // accepted hard reset command
	logic [15:0] top; // current top value
	logic up_wrap; // counting up and at top
	logic dn_wrap; // counting down and at bottom
	logic upd_ev; // update condition from the counter
	logic wrap_ev; // wrap event from the counter
	logic upd; // any update condition
	logic dual; // a dual slope mode is selected
	logic all_bv; // every enabled channel buffer is valid

	// byte address to register index, upper bits must be zero
	function automatic logic [8:0] decode(input logic [31:0] a);
		decode = {(a[31:10] == 22'h000000) && (a[1:0] == 2'h0), a[9:2]};
	endfunction

	// read view of a register; command bits always read zero
	function automatic logic [31:0] read_reg(input twm_state_s r, input logic [7:0] i);
		read_reg = `TWM_ZERO32;
		case (i)
			`TWM_IDX_CTRLA: read_reg[0] = r.enable;
			`TWM_IDX_CTRLB: read_reg[6:0] = {r.compare_pin_output_enable, r.auto_update_lock,
				r.wave_mode_select};
			`TWM_IDX_FORCE: read_reg[2:0] = r.wg;
			`TWM_IDX_SPLIT: read_reg[0] = r.dual_eight_bit_select;
			`TWM_IDX_CMD_CLR, `TWM_IDX_CMD_SET: read_reg[1:0] = {r.update_lock, r.dir};
			`TWM_IDX_BV_CLR, `TWM_IDX_BV_SET: read_reg[3:0] = r.bv;
			`TWM_IDX_FLAGS: read_reg[0] = r.wrap_flag;
			`TWM_IDX_CNT: read_reg[15:0] = r.cnt;
			`TWM_IDX_PERIOD: read_reg[15:0] = r.period_value;
			`TWM_IDX_CMP_CH0: read_reg[15:0] = r.cmp[0];
			`TWM_IDX_CMP1: read_reg[15:0] = r.cmp[1];
			`TWM_IDX_CMP2: read_reg[15:0] = r.cmp[2];
			`TWM_IDX_PERIOD_BUF: read_reg[15:0] = r.period_buffer;
			`TWM_IDX_CMPBUF0: read_reg[15:0] = r.compare_buffer[0];
			`TWM_IDX_CMPBUF1: read_reg[15:0] = r.compare_buffer[1];
			`TWM_IDX_CMPBUF2: read_reg[15:0] = r.compare_buffer[2];
			default: read_reg = `TWM_ZERO32;
		endcase
	endfunction

	// bus answers: reads take one wait state so data comes from a flop
	assign hreadyout = !s.rd_pend;
	assign hresp = 1'b0;
	assign hrdata = s.hrdata;
	assign wave_pins.level = s.wg;
	assign wave_pins.override = s.pin_ovr;

	// counter event decode, shared by the update and wrap logic
	always_comb begin
		wr_fire = s.ph_write && s.ph_hit;
		wr_idx = s.ph_idx;
		cmd = (wr_fire && wr_idx == `TWM_IDX_CMD_SET) ? hwdata[3:2] : `TWM_CMD_NONE;
		// hard reset only honoured while stopped
		hard_rst = (cmd == `TWM_CMD_HARD_RESET) && !s.enable;
		// frequency mode takes channel zero as top
		top = (s.wave_mode_select == TWM_FREQUENCY_WAVE_MODE) ? s.cmp[0] : s.period_value;
		up_wrap = s.enable && !s.dual_eight_bit_select && !s.dir && (s.cnt == top);
		dn_wrap = s.enable && !s.dual_eight_bit_select && s.dir && (s.cnt == `TWM_ZERO16);
		dual = s.wave_mode_select[2] && (s.wave_mode_select[1:0] != 2'h0);
		upd_ev = 1'b0;
		wrap_ev = 1'b0;
		case (s.wave_mode_select)
			TWM_NORMAL, TWM_FREQUENCY_WAVE_MODE: begin
				// top when counting up only
				upd_ev = up_wrap;
				wrap_ev = up_wrap;
			end
			TWM_ONE_RAMP_PWM_MODE: begin
				// the wrap past top lands on bottom
				upd_ev = up_wrap || dn_wrap;
				wrap_ev = up_wrap || dn_wrap;
			end
			TWM_TWO_RAMP_WRAP_AT_TOP: begin
				upd_ev = dn_wrap;
				wrap_ev = up_wrap;
			end
			TWM_TWO_RAMP_WRAP_AT_BOTH: begin
				upd_ev = dn_wrap;
				wrap_ev = up_wrap || dn_wrap;
			end
			TWM_TWO_RAMP_WRAP_AT_BOTTOM: begin
				upd_ev = dn_wrap;
				wrap_ev = dn_wrap;
			end
			default: begin
				// reserved modes raise no events
				upd_ev = 1'b0;
				wrap_ev = 1'b0;
			end
		endcase
		upd = upd_ev || (cmd == `TWM_CMD_UPDATE);
		// an empty set of enabled channels counts as all valid
		all_bv = ((s.bv[3:1] | ~s.compare_pin_output_enable) == 3'h7);
	end

	// next state: counter, update, bus writes, flags, each later step winning over the earlier ones
	always_comb begin
		next_s = s;
		// counter step, hardware side of the direction bit
		if (s.enable && s.dual_eight_bit_select) begin
			// two independent 8-bit down counters
			next_s.cnt[7:0] = (s.cnt[7:0] == 8'h00) ? s.period_value[7:0] :
				s.cnt[7:0] - `TWM_ONE8;
			next_s.cnt[15:8] = (s.cnt[15:8] == 8'h00) ? s.period_value[15:8] :
				s.cnt[15:8] - `TWM_ONE8;
		end else if (s.enable) begin
			if (dual && up_wrap) begin
				next_s.dir = 1'b1;
				next_s.cnt = s.cnt - `TWM_ONE16;
			end else if (dual && dn_wrap) begin
				next_s.dir = 1'b0;
				next_s.cnt = s.cnt + `TWM_ONE16;
			end else if (up_wrap) begin
				next_s.cnt = `TWM_ZERO16;
			end else if (dn_wrap) begin
				next_s.cnt = top;
			end else begin
				// direction bit picks the count sense
				next_s.cnt = s.dir ? s.cnt - `TWM_ONE16 : s.cnt + `TWM_ONE16;
			end
		end
		// waveform generator levels while running
		if (s.enable && !s.dual_eight_bit_select) begin
			for (int n = 0; n < 3; n++) begin
				if (s.wave_mode_select == TWM_FREQUENCY_WAVE_MODE) begin
					next_s.wg[n] = up_wrap ? !s.wg[n] : s.wg[n];
				end else if (s.wave_mode_select == TWM_ONE_RAMP_PWM_MODE || dual) begin
					next_s.wg[n] = (s.cnt < s.cmp[n]);
				end
			end
		end
		// pins follow the generator in every mode but normal, reserved modes included, and per channel enable
		next_s.pin_ovr = (s.wave_mode_select == TWM_NORMAL) ? 3'h0 :
			s.compare_pin_output_enable;
		// update condition: transfer only when unlocked
		if (upd && !s.update_lock) begin
			if (s.bv[0]) begin
				next_s.period_value = s.period_buffer;
			end
			for (int n = 0; n < 3; n++) begin
				if (s.bv[n+1]) begin
					next_s.cmp[n] = s.compare_buffer[n];
				end
			end
		end
		// lock stops every transfer, flags clear regardless
		if (upd) begin
			next_s.bv = 4'h0;
		end
		// auto lock: release when all enabled buffers valid, relock at update
		if (s.auto_update_lock) begin
			if (upd) begin
				next_s.update_lock = 1'b1;
			end else if (all_bv) begin
				next_s.update_lock = 1'b0;
			end
		end
		// restart puts the counter at bottom counting up
		if (cmd == `TWM_CMD_RESTART) begin
			next_s.cnt = `TWM_ZERO16;
			next_s.dir = 1'b0;
		end
		// bus write, software wins over counter hardware
		if (wr_fire) begin
			case (wr_idx)
				`TWM_IDX_CTRLA: next_s.enable = hwdata[0];
				`TWM_IDX_CTRLB: begin
					next_s.wave_mode_select = twm_mode_e'(hwdata[2:0]);
					next_s.auto_update_lock = hwdata[3];
					next_s.compare_pin_output_enable = hwdata[6:4];
					// turning auto lock on locks at once
					if (hwdata[3] && !s.auto_update_lock) begin
						next_s.update_lock = 1'b1;
					end
				end
				`TWM_IDX_FORCE: begin
					// direct level access only while stopped
					if (!s.enable) begin
						next_s.wg = hwdata[2:0];
					end
				end
				`TWM_IDX_SPLIT: next_s.dual_eight_bit_select = hwdata[0];
				`TWM_IDX_CMD_CLR: begin
					// from next_s so a same-cycle auto relock or reversal survives
					next_s.update_lock = next_s.update_lock & ~hwdata[1];
					next_s.dir = next_s.dir & ~hwdata[0];
				end
				`TWM_IDX_CMD_SET: begin
					next_s.update_lock = next_s.update_lock | hwdata[1];
					next_s.dir = next_s.dir | hwdata[0];
				end
				`TWM_IDX_BV_CLR: next_s.bv = next_s.bv & ~hwdata[3:0];
				`TWM_IDX_BV_SET: next_s.bv = next_s.bv | hwdata[3:0];
				`TWM_IDX_CNT: next_s.cnt = hwdata[15:0];
				`TWM_IDX_PERIOD: next_s.period_value = hwdata[15:0];
				`TWM_IDX_CMP_CH0: next_s.cmp[0] = hwdata[15:0];
				`TWM_IDX_CMP1: next_s.cmp[1] = hwdata[15:0];
				`TWM_IDX_CMP2: next_s.cmp[2] = hwdata[15:0];
				`TWM_IDX_PERIOD_BUF: begin
					// a write beats a same-cycle update clear
					next_s.period_buffer = hwdata[15:0];
					next_s.bv[0] = 1'b1;
				end
				`TWM_IDX_CMPBUF0: begin
					next_s.compare_buffer[0] = hwdata[15:0];
					next_s.bv[1] = 1'b1;
				end
				`TWM_IDX_CMPBUF1: begin
					next_s.compare_buffer[1] = hwdata[15:0];
					next_s.bv[2] = 1'b1;
				end
				`TWM_IDX_CMPBUF2: begin
					next_s.compare_buffer[2] = hwdata[15:0];
					next_s.bv[3] = 1'b1;
				end
				default: next_s.enable = next_s.enable;
			endcase
		end
		// wrap flag: write one clears, a same-cycle event still sets it
		if (wr_fire && wr_idx == `TWM_IDX_FLAGS && hwdata[0]) begin
			next_s.wrap_flag = 1'b0;
		end
		if (wrap_ev) begin
			next_s.wrap_flag = 1'b1;
		end
		// hard reset returns every timer field to its reset value
		if (hard_rst) begin
			next_s.enable = 1'b0;
			next_s.wave_mode_select = TWM_NORMAL;
			next_s.compare_pin_output_enable = 3'h0;
			next_s.auto_update_lock = 1'b0;
			next_s.wg = 3'h0;
			next_s.dual_eight_bit_select = 1'b0;
			next_s.update_lock = 1'b0;
			next_s.dir = 1'b0;
			next_s.bv = 4'h0;
			next_s.wrap_flag = 1'b0;
			next_s.cnt = `TWM_ZERO16;
			next_s.period_value = `TWM_PERIOD_RESET;
			next_s.cmp = '0;
			next_s.period_buffer = `TWM_PERIOD_RESET;
			next_s.compare_buffer = '0;
			next_s.pin_ovr = 3'h0;
		end
		// bus pipeline: read data loads in the wait cycle
		next_s.ph_write = 1'b0;
		if (s.rd_pend) begin
			next_s.hrdata = s.ph_hit ? read_reg(s, s.ph_idx) : `TWM_ZERO32;
			next_s.rd_pend = 1'b0;
		end
		if (hsel && htrans[1] && hready) begin
			// unmapped addresses read zero and drop writes
			{next_s.ph_hit, next_s.ph_idx} = decode(haddr);
			next_s.ph_write = hwrite;
			next_s.rd_pend = !hwrite;
		end
	end

	// single state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.period_value <= `TWM_PERIOD_RESET;
			s.period_buffer <= `TWM_PERIOD_RESET;
		end else begin
			s <= next_s;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// normal mode never hands a pin to the generator
	a_normal_no_wave: assert property (
		(s.pin_ovr != 3'h0) |-> ($past(s.wave_mode_select) != TWM_NORMAL))
		else $error("pin override in normal mode");
	// pin override only for enabled channels
	a_pin_gate: assert property (
		(s.pin_ovr & ~$past(s.compare_pin_output_enable)) == 3'h0)
		else $error("pin override without channel enable");
	// force write while stopped lands on the levels
	a_force_level: assert property (
		(wr_fire && wr_idx == `TWM_IDX_FORCE && !s.enable && !hard_rst)
		|=> (s.wg == $past(hwdata[2:0])))
		else $error("force value not applied");
	// command bits read back as zero
	a_cmd_reads_zero: assert property (
		(s.rd_pend && (s.ph_idx == `TWM_IDX_CMD_SET || s.ph_idx == `TWM_IDX_CMD_CLR))
		|=> (hrdata[3:2] == 2'h0) && hreadyout)
		else $error("command bits read nonzero");
	// hard reset ignored while running
	a_hardrst_ignored: assert property (
		(cmd == `TWM_CMD_HARD_RESET && s.enable && !(wr_fire && wr_idx == `TWM_IDX_CTRLA))
		|=> s.enable)
		else $error("hard reset acted while enabled");
	// locked update leaves the period alone
	a_lock_blocks: assert property (
		(upd && s.update_lock && !hard_rst && !(wr_fire && wr_idx == `TWM_IDX_PERIOD))
		|=> $stable(s.period_value))
		else $error("transfer while locked");
	// unlocked update with valid buffer moves it
	a_unlock_copies: assert property (
		(upd && !s.update_lock && s.bv[0] && !hard_rst && !(wr_fire && wr_idx == `TWM_IDX_PERIOD))
		|=> (s.period_value == $past(s.period_buffer)))
		else $error("period buffer not transferred");
	// a period buffer write sets its flag even against an update
	a_bv_set: assert property (
		(wr_fire && wr_idx == `TWM_IDX_PERIOD_BUF) |=> s.bv[0])
		else $error("period buffer valid not set");
	// update without a flag-setting write clears all flags
	a_update_clears: assert property (
		(upd && !(wr_fire && (wr_idx == `TWM_IDX_BV_SET || wr_idx == `TWM_IDX_PERIOD_BUF ||
		wr_idx == `TWM_IDX_CMPBUF0 || wr_idx == `TWM_IDX_CMPBUF1 || wr_idx == `TWM_IDX_CMPBUF2)))
		|=> (s.bv == 4'h0))
		else $error("buffer valid not cleared on update");
	// wrap flag only clears by a one write or a hard reset
	a_wrap_sticky: assert property (
		(s.wrap_flag && !hard_rst && !(wr_fire && wr_idx == `TWM_IDX_FLAGS && hwdata[0]))
		|=> s.wrap_flag)
		else $error("wrap flag lost");
	// dual slope turns at top
	a_dual_reverse: assert property (
		(dual && up_wrap && !wr_fire) |=> (s.dir ##1 (s.cnt != $past(s.cnt))))
		else $error("dual slope did not reverse");
endmodule // twm_timer_ctrl

// file: hdl/twm_defs.svh
// register indices, reset values and command codes of the timer control block
`ifndef TWM_DEFS_SVH
`define TWM_DEFS_SVH
// register indices; byte address is four times the index
`define TWM_IDX_CTRLA 8'h00
`define TWM_IDX_CTRLB 8'h01
`define TWM_IDX_FORCE 8'h02
`define TWM_IDX_SPLIT 8'h03
`define TWM_IDX_CMD_CLR 8'h04
`define TWM_IDX_CMD_SET 8'h05
`define TWM_IDX_BV_CLR 8'h06
`define TWM_IDX_BV_SET 8'h07
`define TWM_IDX_FLAGS 8'h0B
`define TWM_IDX_CNT 8'h20
`define TWM_IDX_PERIOD 8'h26
`define TWM_IDX_CMP_CH0 8'h28
`define TWM_IDX_CMP1 8'h2A
`define TWM_IDX_CMP2 8'h2C
`define TWM_IDX_PERIOD_BUF 8'h36
`define TWM_IDX_CMPBUF0 8'h38
`define TWM_IDX_CMPBUF1 8'h3A
`define TWM_IDX_CMPBUF2 8'h3C
// command codes in the command field
`define TWM_CMD_NONE 2'h0
`define TWM_CMD_UPDATE 2'h1
`define TWM_CMD_RESTART 2'h2
`define TWM_CMD_HARD_RESET 2'h3
// reset values and other constants
`define TWM_PERIOD_RESET 16'hFFFF
`define TWM_ZERO16 16'h0000
`define TWM_ZERO32 32'h00000000
`define TWM_ONE16 16'h0001
`define TWM_ONE8 8'h01
`endif

// file: hdl/twm_pkg.sv
// types shared by the timer wave mode and update control block
package twm_pkg;
	// waveform mode encodings
	typedef enum logic [2:0] {
		TWM_NORMAL = 3'h0,
		TWM_FREQUENCY_WAVE_MODE = 3'h1,
		TWM_RSVD_2 = 3'h2,
		TWM_ONE_RAMP_PWM_MODE = 3'h3,
		TWM_RSVD_4 = 3'h4,
		TWM_TWO_RAMP_WRAP_AT_TOP = 3'h5,
		TWM_TWO_RAMP_WRAP_AT_BOTH = 3'h6,
		TWM_TWO_RAMP_WRAP_AT_BOTTOM = 3'h7
	} twm_mode_e;
	// waveform outputs toward the port pins
	typedef struct packed {
		logic [2:0] level;
		logic [2:0] override;
	} twm_pins_s;
	// the whole state of the block
	typedef struct packed {
		logic enable;
		twm_mode_e wave_mode_select;
		logic [2:0] compare_pin_output_enable;
		logic auto_update_lock;
		logic [2:0] wg;
		logic dual_eight_bit_select;
		logic update_lock;
		logic dir;
		logic [3:0] bv;
		logic wrap_flag;
		logic [15:0] cnt;
		logic [15:0] period_value;
		logic [2:0][15:0] cmp;
		logic [15:0] period_buffer;
		logic [2:0][15:0] compare_buffer;
		logic [2:0] pin_ovr;
		logic ph_write;
		logic ph_hit;
		logic [7:0] ph_idx;
		logic rd_pend;
		logic [31:0] hrdata;
	} twm_state_s;
endpackage

// file: tb/twm_pin_model.sv
// port pin model standing between the timer's waveform outputs and the pads
`timescale 1ns/1ns
module twm_pin_model (
	// from the timer
	input twm_pkg::twm_pins_s wave_pins,
	// port latch and direction set by software
	input wire logic [2:0] port_out,
	input wire logic [2:0] port_dir,
	// pad levels
	output logic [2:0] pin
);
	import twm_pkg::*;
	// input pads fall to the pull-down level, never to a stale value
	always_comb begin
		for (int n = 0; n < 3; n++) begin
			if (!port_dir[n]) begin
				pin[n] = 1'b0;
			end else begin
				// override wins over the port latch
				pin[n] = wave_pins.override[n] ? wave_pins.level[n] : port_out[n];
			end
		end
	end
endmodule // twm_pin_model

// file: tb/testbench.sv
// self-checking testbench of the timer wave mode and update control block
`timescale 1ns/1ns
`include "twm_defs.svh"
module testbench;
	import twm_pkg::*;
	// bus and pins
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize, port_out, port_dir, pin;
	twm_pins_s wave_pins;
	int errors, samples_checked;
	logic [7:0] zero_regs [6];

	twm_timer_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.wave_pins(wave_pins));
	twm_pin_model pins_u (.wave_pins(wave_pins), .port_out(port_out), .port_dir(port_dir),
		.pin(pin));

	// 50 MHz clock
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	// verdict in one place
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// address phase held until ready, then data phase held until ready
	task automatic bus_xfer(input logic [7:0] idx, input logic wr, input logic [31:0] d);
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic bus_wr(input logic [7:0] idx, input logic [31:0] d);
		bus_xfer(idx, 1'b1, d);
	endtask

	task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
		bus_xfer(idx, 1'b0, 32'h0);
		chk(rd, exp);
	endtask

	// lets registered pin outputs land before they are looked at
	task automatic settle;
		repeat (3) @(posedge hclk);
		#1;
	endtask

	// hang guard, about seventeen times the expected run
	initial begin
		repeat (6000) @(posedge hclk);
		errors++;
		end_of_test;
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		port_out = 3'h5;
		port_dir = 3'h7;
		zero_regs = '{`TWM_IDX_FORCE, `TWM_IDX_SPLIT, `TWM_IDX_CMD_CLR, `TWM_IDX_CMD_SET,
			`TWM_IDX_BV_CLR, `TWM_IDX_BV_SET};
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset values and an unmapped place
		chk({26'h0, wave_pins}, 32'h0);
		foreach (zero_regs[i]) rd_chk(zero_regs[i], 32'h0);
		rd_chk(`TWM_IDX_PERIOD, 32'h0000FFFF);
		bus_wr(8'h10, 32'hFFFFFFFF);
		rd_chk(8'h10, 32'h0);
		$display("test reset done");
		// every mode with all channels enabled, then one channel only
		for (int m = 0; m < 8; m++) begin
			bus_wr(`TWM_IDX_CTRLB, {25'h0, 3'h7, 1'b0, 3'(m)});
			settle();
			chk({29'h0, wave_pins.override}, (m == 0) ? 32'h0 : 32'h7);
		end
		bus_wr(`TWM_IDX_CTRLB, 32'h23);
		settle();
		chk({29'h0, wave_pins.override}, 32'h2);
		bus_wr(`TWM_IDX_CTRLB, 32'h70);
		settle();
		chk({29'h0, pin}, {29'h0, port_out});
		$display("test modes done");
		// forced levels while stopped
		bus_wr(`TWM_IDX_FORCE, 32'h5);
		settle();
		chk({29'h0, wave_pins.level}, 32'h5);
		bus_wr(`TWM_IDX_FORCE, 32'h2);
		rd_chk(`TWM_IDX_FORCE, 32'h2);
		bus_wr(`TWM_IDX_SPLIT, 32'h1);
		rd_chk(`TWM_IDX_SPLIT, 32'h1);
		bus_wr(`TWM_IDX_SPLIT, 32'h0);
		$display("test force done");
		// set and clear aliases
		bus_wr(`TWM_IDX_CMD_SET, 32'h3);
		rd_chk(`TWM_IDX_CMD_SET, 32'h3);
		bus_wr(`TWM_IDX_CMD_CLR, 32'h1);
		rd_chk(`TWM_IDX_CMD_CLR, 32'h2);
		bus_wr(`TWM_IDX_CMD_CLR, 32'h2);
		bus_wr(`TWM_IDX_BV_SET, 32'h5);
		rd_chk(`TWM_IDX_BV_SET, 32'h5);
		bus_wr(`TWM_IDX_BV_CLR, 32'h4);
		rd_chk(`TWM_IDX_BV_CLR, 32'h1);
		bus_wr(`TWM_IDX_BV_CLR, 32'h1);
		$display("test alias done");
		// buffers, update unlocked then locked
		bus_wr(`TWM_IDX_PERIOD_BUF, 32'h1234);
		bus_wr(`TWM_IDX_CMPBUF1, 32'h0055);
		rd_chk(`TWM_IDX_BV_SET, 32'h5);
		bus_wr(`TWM_IDX_CMD_SET, {28'h0, `TWM_CMD_UPDATE, 2'h0});
		rd_chk(`TWM_IDX_PERIOD, 32'h1234);
		rd_chk(`TWM_IDX_CMP1, 32'h0055);
		rd_chk(`TWM_IDX_BV_SET, 32'h0);
		rd_chk(`TWM_IDX_CMD_SET, 32'h0);
		bus_wr(`TWM_IDX_CMD_SET, 32'h2);
		bus_wr(`TWM_IDX_PERIOD_BUF, 32'h00AA);
		bus_wr(`TWM_IDX_CMD_SET, {28'h0, `TWM_CMD_UPDATE, 2'h0});
		rd_chk(`TWM_IDX_PERIOD, 32'h1234);
		rd_chk(`TWM_IDX_BV_SET, 32'h0);
		bus_wr(`TWM_IDX_CMD_CLR, 32'h2);
		// auto lock with channel zero enabled
		bus_wr(`TWM_IDX_CTRLB, 32'h1B);
		rd_chk(`TWM_IDX_CMD_SET, 32'h2);
		bus_wr(`TWM_IDX_CMPBUF0, 32'h0010);
		rd_chk(`TWM_IDX_CMD_SET, 32'h0);
		bus_wr(`TWM_IDX_CMD_SET, {28'h0, `TWM_CMD_UPDATE, 2'h0});
		rd_chk(`TWM_IDX_CMD_SET, 32'h2);
		bus_wr(`TWM_IDX_CTRLB, 32'h0);
		bus_wr(`TWM_IDX_CMD_CLR, 32'h2);
		$display("test update done");
		// sticky wrap flag in normal mode
		bus_wr(`TWM_IDX_PERIOD, 32'h0040);
		bus_wr(`TWM_IDX_CTRLA, 32'h1);
		repeat (90) @(posedge hclk);
		rd_chk(`TWM_IDX_FLAGS, 32'h1);
		bus_wr(`TWM_IDX_CMD_SET, {28'h0, `TWM_CMD_RESTART, 2'h0});
		bus_xfer(`TWM_IDX_CNT, 1'b0, 32'h0);
		chk({31'h0, rd < 32'h8}, 32'h1);
		bus_wr(`TWM_IDX_CMD_SET, {28'h0, `TWM_CMD_HARD_RESET, 2'h0});
		rd_chk(`TWM_IDX_PERIOD, 32'h0040);
		bus_wr(`TWM_IDX_CTRLA, 32'h0);
		bus_wr(`TWM_IDX_FLAGS, 32'h0);
		rd_chk(`TWM_IDX_FLAGS, 32'h1);
		bus_wr(`TWM_IDX_FLAGS, 32'h1);
		rd_chk(`TWM_IDX_FLAGS, 32'h0);
		bus_wr(`TWM_IDX_CMD_SET, {28'h0, `TWM_CMD_HARD_RESET, 2'h0});
		rd_chk(`TWM_IDX_PERIOD, 32'h0000FFFF);
		$display("test counter done");
		// dual slope: down after top with a top wrap, up again after bottom
		bus_wr(`TWM_IDX_PERIOD, 32'h0010);
		bus_wr(`TWM_IDX_CTRLB, 32'h05);
		bus_wr(`TWM_IDX_CTRLA, 32'h1);
		repeat (20) @(posedge hclk);
		rd_chk(`TWM_IDX_CMD_SET, 32'h1);
		rd_chk(`TWM_IDX_FLAGS, 32'h1);
		repeat (12) @(posedge hclk);
		rd_chk(`TWM_IDX_CMD_SET, 32'h0);
		bus_wr(`TWM_IDX_CTRLA, 32'h0);
		$display("test dual done");
		end_of_test;
	end
endmodule // testbench
